/* core/flash_read_pkg.sv */
// Shared constants and types of the serial flash read path and status register
package flash_read_pkg;
  // Widths and sizes
  localparam int DATA_W = 8;
  localparam int ADDR_W = 24;
  localparam int ARRAY_W = 19;
  localparam int FIFO_DEPTH = 16;
  localparam int SMALL_SECTOR_LSB = 12;
  localparam int SECTOR_LSB = 16;
  localparam logic [ARRAY_W-1:0] ARRAY_LAST = 19'h7ffff;
  localparam logic [ARRAY_W-1:0] ARRAY_FIRST = 19'h00000;

  // Opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_WEN_SET = 8'h06;
  localparam logic [7:0] OP_WEN_CLR = 8'h04;

  // Header lengths in serial clocks, data shift counts and the filler byte
  localparam logic [4:0] OPCODE_CLKS = 5'h08;
  localparam logic [4:0] ADDR_CLKS_SINGLE = 5'h18;
  localparam logic [4:0] ADDR_CLKS_DUAL = 5'h0c;
  localparam logic [4:0] DUMMY_CLKS_SINGLE = 5'h08;
  localparam logic [4:0] DUMMY_CLKS_DUAL_IO = 5'h04;
  localparam logic [2:0] BITS_LAST_SINGLE = 3'h7;
  localparam logic [2:0] BITS_LAST_DUAL = 3'h3;
  localparam logic [DATA_W-1:0] EMPTY_BYTE = 8'hff;

  // Status register layout
  localparam int ST_BUSY = 0;
  localparam int ST_WEN = 1;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_BOTTOM = 5;
  localparam int ST_RSVD = 6;
  localparam int ST_LOCK = 7;
  localparam logic ST_VOLATILE_RESET = 1'b0;

  // Serial link phases
  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} phase_type;
endpackage : flash_read_pkg

/* core/byte_stream_if.sv */
// Carrier between the fetch logic, the byte FIFO and the serial output logic
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8) ();
  logic wValid;
  logic wReady;
  logic [W-1:0] wData;
  logic flush;
  logic rValid;
  logic rReady;
  logic [W-1:0] rData;
  modport producer (output wValid, output wData, output flush, input wReady);
  modport consumer (input rValid, input rData, output rReady);
  modport store (input wValid, input wData, input flush, input rReady,
                 output wReady, output rValid, output rData);
endinterface : byte_stream_if

/* core/byte_cross_fifo.sv */
// Dual-clock byte FIFO with gray-coded pointers
`timescale 1ns/10ps
module byte_cross_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Fill side
  input wire logic wrClk,
  input wire logic wrEn,
  input wire logic wrRstN,
  // Drain side
  input wire logic rdClk,
  input wire logic rdRst,
  // Stream
  byte_stream_if.store port
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wBin, wGray, rBin, rGray;
  logic [AW:0] rGraySync1, rGraySync2, wGraySync1, wGraySync2;
  logic push, pop;

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : toGray

  // Full when the write pointer is one lap ahead of the read pointer
  assign port.wReady = !port.flush &&
    (wGray != {~rGraySync2[AW:AW-1], rGraySync2[AW-2:0]});
  assign push = port.wValid && port.wReady;
  assign port.rValid = (rGray != wGraySync2);
  assign port.rData = mem[rBin[AW-1:0]];
  assign pop = port.rValid && port.rReady;

  ////////////////////////////////////////////////////////////////////////
  // Fill side pointer, flushed while the link is deselected
  always_ff @(posedge wrClk) begin
    if (!wrRstN) begin
      wBin <= '0;
      wGray <= '0;
      rGraySync1 <= '0;
      rGraySync2 <= '0;
    end else if (wrEn) begin
      rGraySync1 <= rGray;
      rGraySync2 <= rGraySync1;
      if (port.flush) begin
        wBin <= '0;
        wGray <= '0;
      end else if (push) begin
        wBin <= wBin + 1'b1;
        wGray <= toGray(wBin + 1'b1);
      end
    end
  end

  // Storage; read side only looks at entries the gray pointer has published
  always_ff @(posedge wrClk) begin
    if (wrEn && push) begin
      mem[wBin[AW-1:0]] <= port.wData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drain side pointer, cleared asynchronously when the frame ends
  always_ff @(posedge rdClk or posedge rdRst) begin
    if (rdRst) begin
      rBin <= '0;
      rGray <= '0;
      wGraySync1 <= '0;
      wGraySync2 <= '0;
    end else begin
      wGraySync1 <= wGray;
      wGraySync2 <= wGraySync1;
      if (pop) begin
        rBin <= rBin + 1'b1;
        rGray <= toGray(rBin + 1'b1);
      end
    end
  end
endmodule : byte_cross_fifo

/* core/serial_flash_read_status.sv */
// Serial flash read path (four read commands) and status register
// How it works
// - Array is 64 KB sectors of sixteen 4 KB small sectors each.
// - Standard read 03h plus 24-bit address; data starts next falling edge, but this core first sends one FFh filler byte.
// - Fast read 0Bh, address, 8 dummy bits, then single-line data.
// - Dual read 3Bh, address, 8 dummy bits on one line, then dual data.
// - Dual output puts bits 7,5,3,1 on io0 and 6,4,2,0 on io1.
// - Dual I/O read BBh, then address and 4 dummies two bits per clock.
// - Last two dummy clocks of dual I/O read leave both lines undriven.
// - Dual I/O read data starts after last dummy, same bit split.
// - Byte address advances after each byte while the host keeps clocking.
// - Address wraps from 7FFFFh to 00000h without a break in output.
// - Chip select high ends the read and floats the output lines.
// - Eight-bit status: busy, write enable, level, direction, reserved, lock.
// - Bit 0 is busy during erase, program or status write; 0 at power-on.
// - Bit 1 set by 06h, cleared by 04h, 0 at power-on, gates writes.
// - Bits 2-4 protect level, bit 5 direction; all four nonvolatile.
// - Bit 7 nonvolatile lock: with write-protect pin low, blocks status writes.
`timescale 1ns/10ps
module serial_flash_read_status
  import flash_read_pkg::*;
(
  // Core clock and control
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial link
  input wire logic sck,
  input wire logic csN,
  input wire logic io0In,
  output logic io0Out,
  output logic io0OeN,
  input wire logic io1In,
  output logic io1Out,
  output logic io1OeN,
  input wire logic wpN,
  // Array read port
  output logic memRd,
  output logic [flash_read_pkg::ARRAY_W-1:0] memAddr,
  input wire logic [flash_read_pkg::DATA_W-1:0] memData,
  // Status register
  input wire logic flashBusy,
  input wire logic statusWrStrobe,
  input wire logic [flash_read_pkg::DATA_W-1:0] statusWrData,
  input wire logic [flash_read_pkg::DATA_W-1:0] nvStatus,
  output logic [flash_read_pkg::DATA_W-1:0] deviceStatus,
  output logic writeAllowed,
  // Position of the byte being fetched
  output logic [2:0] readSector,
  output logic [6:0] readSmallSector
);
  import flash_read_pkg::*;

  byte_stream_if #(.W(DATA_W)) dataPath ();

  phase_type phase;
  logic [4:0] cnt;
  logic [7:0] opReg;
  logic [ADDR_W-1:0] linkAddr;
  logic addrReady, setWen, clrWen, popSeen;
  logic [DATA_W-1:0] shOut;
  logic [2:0] outCnt;
  logic loadTog, loadedValid, dataOn;
  logic isDualIo, isDualOut;
  logic [4:0] syncA, syncB, syncPrev;
  logic csSync, wpSync, rdySync, rdyRise, setRise, clrRise;
  logic busyPrev, busyFall, rdPend, fetchOn;
  logic [ARRAY_W-1:0] fetchAddr;
  logic wen, lock, statusAccept;
  logic [3:0] level;

  ////////////////////////////////////////////////////////////////////////
  // Link side: header decode on rising sck, cleared by chip select high
  assign isDualIo = (opReg == OP_DUAL_IO);
  assign isDualOut = isDualIo || (opReg == OP_DUAL_OUT);

  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      phase <= PH_OPCODE;
      cnt <= '0;
      opReg <= '0;
      linkAddr <= '0;
      addrReady <= 1'b0;
      setWen <= 1'b0;
      clrWen <= 1'b0;
      popSeen <= 1'b0;
    end else begin
      popSeen <= loadTog;
      case (phase)
        PH_OPCODE: begin
          opReg <= {opReg[6:0], io0In};
          cnt <= cnt + 5'h01;
          if (cnt == OPCODE_CLKS - 5'h01) begin
            cnt <= '0;
            case ({opReg[6:0], io0In})
              OP_READ, OP_FAST, OP_DUAL_OUT, OP_DUAL_IO: phase <= PH_ADDR;
              OP_WEN_SET: begin
                setWen <= 1'b1;
                phase <= PH_IGNORE;
              end
              OP_WEN_CLR: begin
                clrWen <= 1'b1;
                phase <= PH_IGNORE;
              end
              default: phase <= PH_IGNORE;
            endcase
          end
        end
        PH_ADDR: begin
          cnt <= cnt + 5'h01;
          if (isDualIo) begin
            // Odd bit on io1, even on io0, high pair first
            linkAddr <= {linkAddr[ADDR_W-3:0], io1In, io0In};
          end else begin
            linkAddr <= {linkAddr[ADDR_W-2:0], io0In};
          end
          if (cnt == (isDualIo ? ADDR_CLKS_DUAL : ADDR_CLKS_SINGLE) - 5'h01) begin
            cnt <= '0;
            addrReady <= 1'b1;
            // Standard read has no dummy phase
            phase <= (opReg == OP_READ) ? PH_DATA : PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          cnt <= cnt + 5'h01;
          if (cnt == (isDualIo ? DUMMY_CLKS_DUAL_IO : DUMMY_CLKS_SINGLE) - 5'h01) begin
            cnt <= '0;
            phase <= PH_DATA;
          end
        end
        PH_DATA: cnt <= '0;
        PH_IGNORE: cnt <= '0;
        default: phase <= PH_IGNORE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link side: data shifted out on falling sck, one FIFO byte per group
  always_ff @(negedge sck or posedge csN) begin
    if (csN) begin
      shOut <= '0;
      outCnt <= '0;
      loadTog <= 1'b0;
      loadedValid <= 1'b0;
      dataOn <= 1'b0;
    end else if (phase == PH_DATA) begin
      dataOn <= 1'b1;
      if (outCnt == 3'h0) begin
        // An empty FIFO means the fetch fell behind; send all ones
        shOut <= dataPath.rValid ? dataPath.rData : EMPTY_BYTE;
        loadedValid <= dataPath.rValid;
        loadTog <= ~loadTog;
        outCnt <= isDualOut ? BITS_LAST_DUAL : BITS_LAST_SINGLE;
      end else begin
        shOut <= isDualOut ? {shOut[5:0], 2'b00} : {shOut[6:0], 1'b0};
        outCnt <= outCnt - 3'h1;
      end
    end
  end

  // Byte is popped at the rising edge after it was loaded
  assign dataPath.rReady = (loadTog != popSeen) && loadedValid;

  // Bit 7,5,3,1 on io0 and 6,4,2,0 on io1 in dual mode
  assign io0Out = shOut[7];
  assign io1Out = isDualOut ? shOut[6] : shOut[7];
  // Lines float until data phase, so dual I/O dummies stay released
  assign io1OeN = !dataOn;
  assign io0OeN = !(dataOn && isDualOut);

  ////////////////////////////////////////////////////////////////////////
  // Core side: two-stage synchronisers for pins and link levels
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      syncA <= 5'h18;
      syncB <= 5'h18;
      syncPrev <= 5'h18;
    end else if (clk_en) begin
      syncA <= {csN, wpN, addrReady, setWen, clrWen};
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  assign csSync = syncB[4];
  assign wpSync = syncB[3];
  assign rdySync = syncB[2];
  assign rdyRise = syncB[2] && !syncPrev[2];
  assign setRise = syncB[1] && !syncPrev[1];
  assign clrRise = syncB[0] && !syncPrev[0];

  ////////////////////////////////////////////////////////////////////////
  // Core side: sequential array fetch into the FIFO
  assign dataPath.flush = csSync;
  assign memRd = fetchOn && !rdPend && dataPath.wReady && clk_en;
  assign dataPath.wValid = rdPend && !csSync;
  assign dataPath.wData = memData;
  assign memAddr = fetchAddr;
  assign readSector = fetchAddr[ARRAY_W-1:SECTOR_LSB];
  assign readSmallSector = fetchAddr[ARRAY_W-1:SMALL_SECTOR_LSB];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fetchOn <= 1'b0;
      rdPend <= 1'b0;
      fetchAddr <= ARRAY_FIRST;
    end else if (clk_en) begin
      rdPend <= memRd;
      if (csSync) begin
        fetchOn <= 1'b0;
      end else if (rdyRise) begin
        // Address word is stable while its ready level is high
        fetchOn <= 1'b1;
        fetchAddr <= linkAddr[ARRAY_W-1:0];
      end else if (memRd) begin
        fetchAddr <= (fetchAddr == ARRAY_LAST) ? ARRAY_FIRST
                                               : fetchAddr + 19'h00001;
      end
    end
  end

  byte_cross_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) fifo (
    .wrClk(core_clk),
    .wrEn(clk_en),
    .wrRstN(rst_n),
    .rdClk(sck),
    .rdRst(csN),
    .port(dataPath.store)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status register; nonvolatile image is taken at reset
  assign busyFall = busyPrev && !flashBusy;
  assign statusAccept = statusWrStrobe && wen && !flashBusy && (wpSync || !lock);
  assign writeAllowed = wen;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busyPrev <= 1'b0;
      wen <= ST_VOLATILE_RESET;
    end else if (clk_en) begin
      busyPrev <= flashBusy;
      // Set wins when it meets a clear in the same cycle
      if (setRise) begin
        wen <= 1'b1;
      end else if (clrRise || busyFall) begin
        wen <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level <= nvStatus[ST_BOTTOM:ST_LEVEL_LSB];
      lock <= nvStatus[ST_LOCK];
    end else if (clk_en && statusAccept) begin
      // Busy, write enable and reserved bits are not writable
      level <= statusWrData[ST_BOTTOM:ST_LEVEL_LSB];
      lock <= statusWrData[ST_LOCK];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      deviceStatus <= '0;
    end else if (clk_en) begin
      deviceStatus <= {lock, 1'b0, level, wen, flashBusy};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_fast_header_done;
    phase == PH_ADDR && opReg == OP_FAST && cnt == ADDR_CLKS_SINGLE - 5'h01;
  endsequence
  sequence s_eight_dummies;
    (phase == PH_DUMMY)[*8] ##1 (phase == PH_DATA);
  endsequence

  a_fast_dummy_len: assert property (@(posedge sck) disable iff (csN)
    s_fast_header_done |=> s_eight_dummies)
    else $error("fast read dummy phase length wrong");

  a_std_no_dummy: assert property (@(posedge sck) disable iff (csN)
    phase == PH_ADDR && opReg == OP_READ && cnt == ADDR_CLKS_SINGLE - 5'h01
    |=> phase == PH_DATA && addrReady)
    else $error("standard read did not enter data phase");

  a_dualio_release: assert property (@(posedge sck) disable iff (csN)
    phase == PH_DUMMY && isDualIo |-> io0OeN && io1OeN)
    else $error("line driven during dual I/O dummy");

  a_single_io0_free: assert property (@(negedge sck) disable iff (csN)
    !isDualOut |-> io0OeN)
    else $error("io0 driven in single read");

  a_deselect_float: assert property (@(posedge core_clk) disable iff (!rst_n)
    csN |-> io0OeN && io1OeN)
    else $error("line driven while deselected");

  a_addr_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    memRd && fetchAddr == ARRAY_LAST && !csSync && !rdyRise |=> fetchAddr == ARRAY_FIRST)
    else $error("address did not wrap");

  a_addr_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    memRd && fetchAddr != ARRAY_LAST && !csSync && !rdyRise
    |=> fetchAddr == $past(fetchAddr) + 19'h00001)
    else $error("address did not advance");

  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    deviceStatus[ST_RSVD] == 1'b0)
    else $error("reserved status bit set");

  a_wen_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && setRise ##1 clk_en |=> deviceStatus[ST_WEN])
    else $error("write enable not shown after set");

  a_lock_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && statusWrStrobe && lock && !wpSync |=> level == $past(level) && lock)
    else $error("locked status register changed");

  a_busy_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> deviceStatus[ST_BUSY] == $past(flashBusy))
    else $error("busy bit does not follow busy input");

  a_dual_shift: assert property (@(negedge sck) disable iff (csN)
    phase == PH_DATA && isDualOut && outCnt != 3'h0 |=> shOut == {$past(shOut[5:0]), 2'b00})
    else $error("dual output did not move two bits");

  a_level_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && statusAccept ##1 clk_en
    |=> deviceStatus[ST_BOTTOM:ST_LEVEL_LSB] == $past(statusWrData[ST_BOTTOM:ST_LEVEL_LSB], 2))
    else $error("protect level not taken from write");

  a_lock_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && statusAccept ##1 clk_en
    |=> deviceStatus[ST_LOCK] == $past(statusWrData[ST_LOCK], 2))
    else $error("lock bit not taken from write");

  a_wen_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && clrRise && !setRise ##1 clk_en |=> !deviceStatus[ST_WEN])
    else $error("write enable not dropped after clear");
endmodule : serial_flash_read_status

/* bench/host_flash_ctrl.sv */
// Behavioural host controller that runs frames on the serial link
`timescale 1ns/10ps
module host_flash_ctrl (
  // Serial link toward the device
  output logic sck,
  output logic csN,
  output logic io0In,
  output logic io1In,
  // Device drivers
  input wire logic io0Out,
  input wire logic io0OeN,
  input wire logic io1Out,
  input wire logic io1OeN
);
  logic [7:0] rx [0:7];
  logic hostOe0 = 1'b0;
  logic hostOe1 = 1'b0;
  logic bit0 = 1'b0;
  logic bit1 = 1'b0;
  logic tog = 1'b0;
  int oeBad = 0;
  // Wire level from all drivers; a released line toggles so stale data cannot pass
  assign io0In = hostOe0 ? bit0 : (!io0OeN ? io0Out : tog);
  assign io1In = hostOe1 ? bit1 : (!io1OeN ? io1Out : ~tog);
  // Select raised after time zero so the link flops surely see the edge that clears them
  initial begin
    sck = 1'b0;
    #1 csN = 1'b1;
  end
  // Header clock; the last address clock, or the last opcode clock of an opcode-only frame, is stretched high so the fetch lands
  // and the dummy clocks that follow carry the FIFO pointer into the link domain
  task automatic hclk(input logic last);
    if (io0OeN !== 1'b1 || io1OeN !== 1'b1) oeBad++;
    tog = ~tog;
    #3 sck = 1'b1;
    #(last ? 120 : 3) sck = 1'b0;
  endtask : hclk
  // Whole frame: opcode, address, dummies, then data bytes into rx
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int dummy,
                       input logic dualAddr, input logic dualData, input int nBytes);
    int i;
    int k;
    logic [7:0] b;
    csN = 1'b0;
    hostOe0 = 1'b1;
    #6;
    for (i = 7; i >= 0; i--) begin
      bit0 = op[i];
      hclk(i == 0 && nBytes == 0);
    end
    if (nBytes > 0) begin
      hostOe1 = dualAddr;
      for (i = dualAddr ? 11 : 23; i >= 0; i--) begin
        bit1 = dualAddr ? addr[2*i+1] : 1'b0;
        bit0 = dualAddr ? addr[2*i] : addr[i];
        hclk(i == 0);
      end
      for (i = 0; i < dummy; i++) begin
        // Release both lines for the last two dummies before dual output
        if (dualData && i >= dummy - 2) begin
          hostOe0 = 1'b0;
          hostOe1 = 1'b0;
        end
        hclk(1'b0);
      end
      hostOe1 = 1'b0;
      if (dualData) hostOe0 = 1'b0;
      for (k = 0; k < nBytes; k++) begin
        for (i = 0; i < (dualData ? 4 : 8); i++) begin
          tog = ~tog;
          #3 sck = 1'b1;
          b = dualData ? {b[5:0], io0In, io1In} : {b[6:0], io1In};
          #3 sck = 0;
        end
        rx[k] = b;
      end
    end
    #3 csN = 1'b1;
    hostOe0 = 1'b0;
    hostOe1 = 1'b0;
    #40;
  endtask : frame
endmodule : host_flash_ctrl

/* bench/testbench.sv */
// Self-checking bench for the serial flash read path and status register
`timescale 1ns/10ps
module testbench;
  import flash_read_pkg::*;
  logic core_clk;
  logic rst_n;
  logic clk_en;
  logic sck;
  logic csN;
  logic io0In;
  logic io0Out;
  logic io0OeN;
  logic io1In;
  logic io1Out;
  logic io1OeN;
  logic wpN;
  logic memRd;
  logic [ARRAY_W-1:0] memAddr;
  logic [DATA_W-1:0] memData;
  logic flashBusy;
  logic statusWrStrobe;
  logic [DATA_W-1:0] statusWrData;
  logic [DATA_W-1:0] nvStatus;
  logic [DATA_W-1:0] deviceStatus;
  logic writeAllowed;
  logic [2:0] readSector;
  logic [6:0] readSmallSector;
  int errors = 0;
  int num_checks = 0;

  serial_flash_read_status i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sck(sck), .csN(csN), .io0In(io0In), .io0Out(io0Out), .io0OeN(io0OeN),
    .io1In(io1In), .io1Out(io1Out), .io1OeN(io1OeN), .wpN(wpN), .memRd(memRd),
    .memAddr(memAddr), .memData(memData), .flashBusy(flashBusy),
    .statusWrStrobe(statusWrStrobe), .statusWrData(statusWrData), .nvStatus(nvStatus),
    .deviceStatus(deviceStatus), .writeAllowed(writeAllowed), .readSector(readSector),
    .readSmallSector(readSmallSector));
  host_flash_ctrl i_host (.sck(sck), .csN(csN), .io0In(io0In), .io1In(io1In),
    .io0Out(io0Out), .io0OeN(io0OeN), .io1Out(io1Out), .io1OeN(io1OeN));

  ////////////////////////////////////////////////////////////////////////////////
  // Array content is a function of the address so wrap shows in the data
  function automatic logic [7:0] pat(input logic [ARRAY_W-1:0] a);
    return a[7:0] + {1'b0, a[18:12]};
  endfunction : pat
  // Array model answers one cycle after the request
  always_ff @(posedge core_clk) begin
    if (memRd) memData <= pat(memAddr);
  end
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // Status write; write-protect pin settles through its synchroniser first
  task automatic wr_status(input logic wp, input logic [7:0] d);
    wpN <= wp;
    repeat (4) @(posedge core_clk);
    statusWrStrobe <= 1'b1;
    statusWrData <= d;
    @(posedge core_clk);
    statusWrStrobe <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : wr_status
  // Read frame, then compare every byte and the idle line state
  task automatic rd(input logic [7:0] op, input logic [23:0] addr, input int dummy,
                    input logic dA, input logic dD, input int n);
    int k;
    logic [ARRAY_W-1:0] a;
    logic [7:0] e;
    i_host.frame(op, addr, dummy, dA, dD, n);
    for (k = 0; k < n; k++) begin
      // Standard read has no dummy clocks to carry the fetch across: first byte is filler
      a = addr[ARRAY_W-1:0] + ARRAY_W'(k) - ((op == OP_READ) ? 19'h00001 : 19'h00000);
      e = (op == OP_READ && k == 0) ? EMPTY_BYTE : pat(a);
      check("read byte", i_host.rx[k], e);
    end
    check("io0 idle", io0OeN, 1'b1);
    check("io1 idle", io1OeN, 1'b1);
    check("header drive", i_host.oeBad, 0);
    check("sector", readSector, memAddr / 65536);
    check("small sector", readSmallSector, memAddr / 4096);
    $display("test read %h done", op);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    wpN = 1'b1;
    flashBusy = 1'b0;
    statusWrStrobe = 1'b0;
    statusWrData = 8'h00;
    nvStatus = 8'hff;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("status reset", deviceStatus, 8'hbc);
    check("wen reset", writeAllowed, 1'b0);
    // Clock enable low must freeze the status image
    clk_en <= 1'b0;
    flashBusy <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("frozen busy", deviceStatus[ST_BUSY], 1'b0);
    clk_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("busy set", deviceStatus[ST_BUSY], 1'b1);
    flashBusy <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("busy clear", deviceStatus[ST_BUSY], 1'b0);
    $display("test reset and busy done");
    i_host.frame(OP_WEN_SET, 24'h000000, 0, 1'b0, 1'b0, 0);
    repeat (3) @(posedge core_clk);
    check("wen set", writeAllowed, 1'b1);
    wr_status(1'b0, 8'h00);
    check("locked write", deviceStatus, 8'hbe);
    wr_status(1'b1, 8'h43);
    check("pin high write", deviceStatus, 8'h02);
    wr_status(1'b0, 8'hbc);
    check("unlocked write", deviceStatus, 8'hbe);
    i_host.frame(OP_WEN_CLR, 24'h000000, 0, 1'b0, 1'b0, 0);
    repeat (3) @(posedge core_clk);
    check("wen clear", writeAllowed, 1'b0);
    wr_status(1'b1, 8'h00);
    check("no wen write", deviceStatus, 8'hbc);
    $display("test status done");
    rd(OP_READ, 24'hf12345, 0, 1'b0, 1'b0, 4);
    rd(OP_FAST, 24'hfffffd, 8, 1'b0, 1'b0, 6);
    rd(OP_DUAL_OUT, 24'h040ffe, 8, 1'b0, 1'b1, 4);
    rd(OP_DUAL_IO, 24'h0abcde, 4, 1'b1, 1'b1, 4);
    rd(OP_DUAL_IO, 24'h07fffe, 4, 1'b1, 1'b1, 3);
    print_verdict();
  end
endmodule : testbench
